// file: logic/dsk_deskew_clock_dll.sv
// synthesizable model of a delay-locked clock manager with deskew, doubler and divider
// assumes source and feedback clocks are sampled as synchronous inputs on ref_clk
//
// What this block does
// R1 - reset drops lock within four source cycles
// R2 - reset clears delay taps; outputs not deskewed
// R3 - user drives reset dynamically or ties low
// R4 - locked doubler runs twice source, 50/50
// R5 - unlocked doubler is 1x at 25/75
// R6 - divider divides by selected ratio N
// R7 - divider 50/50; hf non-integer 1/3, 2/5
// R8 - high-frequency variant has no doubler
// R9 - only 1x or doubler feeds back
// R10 - align feedback edge to source via taps
// R11 - optionally hold configuration done until lock
// R12 - two chained instances multiply by four
// R13 - simple macro output 50/50 unless correction off
// R14 - simple macro: no reset, lock, multiply, divide
// R15 - source from global buffer, pad, differential pin
// R16 - pad feedback with both off-chip: return doubler
// R17 - drive at most two global clock networks
// R18 - unconfigured divide ratio defaults to two
// R19 - lock rises only after delay line locks
// R20 - quadrature copies; hf variant only 180
// R21 - lock after consecutive matching feedback edges
`timescale 1ns/1ps

module dsk_deskew_clock_dll #(
    parameter int LOCK_COUNT = dsk_pkg::LOCK_COUNT_DEFAULT
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic source_clk_in,
    input wire logic feedback_clk_in,
    input wire logic dll_reset_in,
    input wire dsk_pkg::dsk_variant_t variant_select,
    input wire logic duty_correct_enable,
    input wire logic [2:0] divide_ratio_setting,
    input wire logic high_freq_mode,
    input wire logic startup_wait_enable,
    input wire logic config_done_request,
    input wire logic [1:0] global_net_enable,
    output logic deskewed_clk_out,
    output logic phase90_clk_out,
    output logic phase180_clk_out,
    output logic phase270_clk_out,
    output logic doubled_clk_out,
    output logic divided_clk_out,
    output logic [1:0] global_net_out,
    output logic dll_locked_out,
    output logic config_done_out
);

    // -----------------------------------------------------------------
    // edge detection and period measurement
    // -----------------------------------------------------------------
    logic src_d;
    logic fb_d;
    logic [11:0] phase;
    logic [11:0] period;
    logic [11:0] tap;
    logic [5:0] lock_cnt;
    logic [17:0] dv_cnt;
    dsk_pkg::dsk_state_t state;

    wire is_simple = (variant_select == dsk_pkg::VAR_SIMPLE);
    wire is_hf = (variant_select == dsk_pkg::VAR_HF);
    // simple macro has no reset pin, so the user reset is ignored there
    wire rst_eff = srst | (dll_reset_in & ~is_simple);
    wire src_rise = source_clk_in & ~src_d;
    wire fb_rise = feedback_clk_in & ~fb_d;
    wire period_ok = (period != dsk_pkg::TAP_RESET);
    wire [11:0] next_phase = src_rise ? dsk_pkg::TAP_RESET :
        (phase == dsk_pkg::PERIOD_MAX) ? phase : phase + dsk_pkg::PERIOD_ONE;

    // period keeps its last good value across the delay-line reset
    // edge history follows the pins during reset, so a high source at release is no false edge
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            src_d <= source_clk_in;
            fb_d <= feedback_clk_in;
            phase <= dsk_pkg::TAP_RESET;
            period <= dsk_pkg::TAP_RESET;
        end else begin
            src_d <= source_clk_in;
            fb_d <= feedback_clk_in;
            phase <= next_phase;
            if (src_rise) begin
                period <= (phase == dsk_pkg::PERIOD_MAX) ? phase : phase + dsk_pkg::PERIOD_ONE;
            end
        end
    end

    // -----------------------------------------------------------------
    // phase alignment and lock detection
    // -----------------------------------------------------------------
    wire [11:0] half_p = period >> 1;
    wire [11:0] quarter_p = period >> 2;
    wire [11:0] three_q = half_p + quarter_p;
    // feedback edge position after the source edge is the network delay still uncancelled
    wire fb_match = (phase <= dsk_pkg::MATCH_WIN) || (phase >= period - dsk_pkg::MATCH_WIN);
    wire fb_late = (phase < half_p);
    wire [11:0] tap_up = (tap + dsk_pkg::PERIOD_ONE >= period) ? dsk_pkg::TAP_RESET :
        tap + dsk_pkg::PERIOD_ONE;
    wire [11:0] tap_dn = (tap == dsk_pkg::TAP_RESET) ? period - dsk_pkg::PERIOD_ONE :
        tap - dsk_pkg::PERIOD_ONE;
    wire tracking = (state != dsk_pkg::ST_RESET) && fb_rise;
    wire [11:0] next_tap = (tracking && !fb_match) ? (fb_late ? tap_up : tap_dn) : tap;
    wire lock_hit = tracking && fb_match && (32'(lock_cnt) >= LOCK_COUNT - 1);

    // one tap step per feedback edge keeps the loop slow and free of overshoot
    always_ff @(posedge ref_clk) begin
        if (rst_eff) begin
            tap <= dsk_pkg::TAP_RESET; // R2
            lock_cnt <= 6'h00;
            state <= dsk_pkg::ST_RESET;
        end else begin
            tap <= next_tap; // R10
            if (tracking) begin
                lock_cnt <= fb_match ? lock_cnt + 6'h01 : 6'h00; // R21
            end
            case (state)
                dsk_pkg::ST_RESET: state <= period_ok ? dsk_pkg::ST_ACQ : dsk_pkg::ST_RESET;
                dsk_pkg::ST_ACQ: state <= lock_hit ? dsk_pkg::ST_LOCKED : dsk_pkg::ST_ACQ; // R19
                dsk_pkg::ST_LOCKED: state <= dsk_pkg::ST_LOCKED;
                default: state <= dsk_pkg::ST_RESET;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // output waveform decode
    // -----------------------------------------------------------------
    // output is advanced by the tap so that the returned edge lands on the source edge
    wire [12:0] shift_sum = {1'b0, phase} + {1'b0, tap};
    wire [12:0] shift_wrap = (shift_sum >= {1'b0, period}) ? shift_sum - {1'b0, period} : shift_sum;
    wire [11:0] sh = shift_wrap[11:0];
    wire is_locked = (state == dsk_pkg::ST_LOCKED);
    // with correction off the source duty passes through, at the cost of any skew
    wire lvl_0 = duty_correct_enable ? (sh < half_p) : source_clk_in; // R13
    wire lvl_90 = (sh >= quarter_p) && (sh < three_q); // R20
    wire lvl_180 = (sh >= half_p);
    wire lvl_270 = (sh >= three_q) || (sh < quarter_p);
    wire dbl_lock = (sh < quarter_p) || ((sh >= half_p) && (sh < three_q)); // R4
    wire dbl_pre = (sh < quarter_p); // R5
    wire lvl_dbl = (is_hf || is_simple) ? 1'b0 : (is_locked ? dbl_lock : dbl_pre); // R8
    wire [5:0] ratio2x = dsk_pkg::dsk_ratio_twice(divide_ratio_setting); // R18
    wire [17:0] dv_period = 18'(ratio2x * half_p); // R6
    wire [17:0] dv_high_hf = 18'((ratio2x >> 1) * half_p);
    wire [17:0] dv_high = (high_freq_mode && ratio2x[0]) ? dv_high_hf : dv_period >> 1; // R7
    wire dv_wrap = (dv_cnt >= dv_period - dsk_pkg::DV_ONE);
    wire [17:0] next_dv_cnt = (!period_ok || dv_wrap) ? 18'h00000 : dv_cnt + dsk_pkg::DV_ONE;
    wire lvl_dv = is_simple ? 1'b0 : (dv_cnt < dv_high);
    wire next_done = config_done_request & (~startup_wait_enable | (is_locked & ~is_simple));

    // all clock and status outputs leave from flip-flops to keep them glitch free in the model
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            dv_cnt <= 18'h00000;
            deskewed_clk_out <= 1'b0;
            phase90_clk_out <= 1'b0;
            phase180_clk_out <= 1'b0;
            phase270_clk_out <= 1'b0;
            doubled_clk_out <= 1'b0;
            divided_clk_out <= 1'b0;
            global_net_out <= 2'h0;
            dll_locked_out <= 1'b0;
            config_done_out <= 1'b0;
        end else begin
            dv_cnt <= next_dv_cnt;
            deskewed_clk_out <= lvl_0;
            phase90_clk_out <= lvl_90 & ~is_hf & ~is_simple;
            phase180_clk_out <= lvl_180 & ~is_simple;
            phase270_clk_out <= lvl_270 & ~is_hf & ~is_simple;
            doubled_clk_out <= lvl_dbl; // R12
            divided_clk_out <= lvl_dv;
            global_net_out <= global_net_enable & {2{lvl_0}}; // R17
            dll_locked_out <= is_locked & ~is_simple & ~rst_eff; // R1 R14
            config_done_out <= next_done; // R11
        end
    end

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    lock_drop_a: assert property ($rose(rst_eff) |=> !dll_locked_out) // R1
        else $error("lock still high after reset");
    tap_clear_a: assert property (rst_eff |=> tap == dsk_pkg::TAP_RESET) // R2
        else $error("taps not cleared by reset");
    dbl_hf_off_a: assert property (is_hf |=> !doubled_clk_out) // R8
        else $error("doubler active in high-frequency variant");
    dbl_prelock_a: assert property ((state == dsk_pkg::ST_ACQ && sh >= quarter_p
        && !rst_eff) |=> !doubled_clk_out) // R5
        else $error("doubler high outside first quarter before lock");
    lock_rise_a: assert property ($rose(dll_locked_out) |-> $past(is_locked)
        && !$past(is_locked, 2)) // R19
        else $error("lock rose without delay line lock");
    dv_wrap_a: assert property ((period_ok && dv_wrap) |=> dv_cnt == 18'h00000) // R6
        else $error("divider counter failed to wrap");
    cfg_hold_a: assert property ((startup_wait_enable && !is_locked) |=> !config_done_out) // R11
        else $error("configuration done before lock");
    simple_bare_a: assert property (is_simple |=> !dll_locked_out && !divided_clk_out
        && !doubled_clk_out) // R14
        else $error("simple macro shows lock, divide or doubler");
    tap_step_a: assert property ((tracking && !fb_match && !rst_eff && period_ok)
        |=> tap != $past(tap)) // R10
        else $error("tap did not move on mismatched feedback");
    half_inv_a: assert property ((duty_correct_enable && !is_simple)
        |=> phase180_clk_out != deskewed_clk_out) // R20
        else $error("half-period copy not inverse of 1x output");
    net_gate_a: assert property (1'b1
        |=> (global_net_out & ~$past(global_net_enable)) == 2'h0) // R17
        else $error("global network driven while not enabled");

    lock_seen_c: cover property ($rose(dll_locked_out));
    hf_frac_c: cover property (high_freq_mode && divide_ratio_setting == dsk_pkg::DIV_1P5
        && $rose(divided_clk_out));
    no_dcc_c: cover property (!duty_correct_enable && is_locked && $rose(deskewed_clk_out));
    relock_c: cover property (is_locked ##1 rst_eff ##[1:400] is_locked);
    hf_half_c: cover property (is_hf && $rose(phase180_clk_out));

endmodule : dsk_deskew_clock_dll

// file: logic/dsk_pkg.sv
// constants, codes and types shared by the deskew clock manager model
// assumes ref_clk oversamples the source clock by several cycles per period
package dsk_pkg;

    // -----------------------------------------------------------------
    // timing and widths
    // -----------------------------------------------------------------
    localparam int REF_CLK_HZ = 40000000;
    localparam int PW = 12;                        // phase and period counter width
    localparam int DW = 18;                        // divided-clock counter width
    localparam logic [11:0] PERIOD_MAX = 12'hFFF;  // longest measurable source period
    localparam logic [11:0] PERIOD_ONE = 12'h001;
    localparam logic [11:0] MATCH_WIN = 12'h001;   // one delay-line step either side
    localparam logic [11:0] TAP_RESET = 12'h000;
    localparam logic [17:0] DV_ONE = 18'h00001;
    localparam int LOCK_COUNT_DEFAULT = 16;

    // -----------------------------------------------------------------
    // modes and states
    // -----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RESET  = 3'b001,
        ST_ACQ    = 3'b010,
        ST_LOCKED = 3'b100
    } dsk_state_t;

    typedef enum logic [1:0] {
        VAR_FULL   = 2'h0,
        VAR_HF     = 2'h1,
        VAR_SIMPLE = 2'h2
    } dsk_variant_t;

    // divide ratio codes; code zero is the unconfigured default of two
    localparam logic [2:0] DIV_2 = 3'h0;
    localparam logic [2:0] DIV_1P5 = 3'h1;
    localparam logic [2:0] DIV_2P5 = 3'h2;
    localparam logic [2:0] DIV_3 = 3'h3;
    localparam logic [2:0] DIV_4 = 3'h4;
    localparam logic [2:0] DIV_5 = 3'h5;
    localparam logic [2:0] DIV_8 = 3'h6;
    localparam logic [2:0] DIV_16 = 3'h7;

    // ratio expressed in half source periods
    function automatic logic [5:0] dsk_ratio_twice(input logic [2:0] code);
        logic [5:0] r;
        r = 6'h04;
        case (code)
            DIV_1P5: r = 6'h03;
            DIV_2P5: r = 6'h05;
            DIV_3: r = 6'h06;
            DIV_4: r = 6'h08;
            DIV_5: r = 6'h0A;
            DIV_8: r = 6'h10;
            DIV_16: r = 6'h20;
            default: r = 6'h04;
        endcase
        return r;
    endfunction : dsk_ratio_twice

endpackage : dsk_pkg

// file: verification/deskew_clock_dll_tb_top.sv
// self-checking bench for the deskew clock manager, source period 16 ref cycles
// assumes the fabric model returns the 1x output; lock count shortened to 4
`timescale 1ns/1ps
module deskew_clock_dll_tb_top;
    logic ref_clk = 1'b0, srst = 1'b1, dll_reset_in = 1'b0, duty_correct_enable = 1'b1;
    logic high_freq_mode = 1'b0, startup_wait_enable = 1'b1, config_done_request = 1'b1;
    logic [2:0] divide_ratio_setting = 3'h0;
    logic [1:0] global_net_enable = 2'h1;
    dsk_pkg::dsk_variant_t variant_select = dsk_pkg::VAR_FULL;
    logic src, fb, c1x, c90, c180, c270, c2x, cdv, lck, cdone;
    logic [1:0] gnet;
    int failures = 0, n_checks = 0, hi, rs, eq;
    int r2[8] = '{4, 3, 5, 6, 8, 10, 16, 32};
    always #12.5 ref_clk = ~ref_clk;
    dsk_fabric_model #(.PERIOD(16), .DELAY(5)) fab (.ref_clk(ref_clk), .loop_clk(c1x),
        .source_clk(src), .feedback_clk(fb));
    dsk_deskew_clock_dll #(.LOCK_COUNT(4)) dut (.ref_clk(ref_clk), .srst(srst),
        .source_clk_in(src), .feedback_clk_in(fb), .dll_reset_in(dll_reset_in),
        .variant_select(variant_select), .duty_correct_enable(duty_correct_enable),
        .divide_ratio_setting(divide_ratio_setting), .high_freq_mode(high_freq_mode),
        .startup_wait_enable(startup_wait_enable), .config_done_request(config_done_request),
        .global_net_enable(global_net_enable), .deskewed_clk_out(c1x), .phase90_clk_out(c90),
        .phase180_clk_out(c180), .phase270_clk_out(c270), .doubled_clk_out(c2x),
        .divided_clk_out(cdv), .global_net_out(gnet), .dll_locked_out(lck),
        .config_done_out(cdone));
    // ----------------------------------------------------------------
    // shared helpers
    // ----------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (exp !== got) begin
            failures++;
            $display("Error %s expected %0d seen %0d", what, exp, got);
        end
    endtask : chk
    function automatic logic pick(input int sel);
        case (sel)
            0: return c1x;
            1: return c2x;
            2: return cdv;
            3: return lck;
            4: return gnet[0];
            5: return gnet[1];
            6: return c90;
            7: return c180;
            8: return c270;
            default: return src;
        endcase
    endfunction : pick
    // counts high samples and rising edges over n cycles, sampled after settling
    task automatic watch(input int sel, input int n, output int h, output int r);
        logic p;
        logic c;
        h = 0;
        r = 0;
        p = pick(sel);
        repeat (n) begin
            @(posedge ref_clk);
            #2;
            c = pick(sel);
            if (c !== 1'b0 && c !== 1'b1) chk("level known", 1, 0);
            h += int'(c === 1'b1);
            r += int'(c === 1'b1 && p === 1'b0);
            p = c;
        end
    endtask : watch
    // counts samples over n cycles at which two picked levels agree
    task automatic watch_eq(input int sa, input int sb, input int n, output int e);
        e = 0;
        repeat (n) begin
            @(posedge ref_clk);
            #2;
            e += int'(pick(sa) === pick(sb));
        end
    endtask : watch_eq
    // bounded wait for the lock level to reach want
    task automatic wait_lock(input logic want, input int lim);
        int i;
        for (i = 0; i < lim && lck !== want; i++) @(posedge ref_clk);
        #2;
        chk("lock level", 1, int'(lck === want));
        if (lck !== want) tally_and_finish();
    endtask : wait_lock
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_lock();
        watch(3, 32, hi, rs);
        chk("early lock", 0, hi);
        chk("done held", 0, cdone);
        wait_lock(1'b1, 2000);
        watch(0, 64, hi, rs);
        chk("1x high", 32, hi);
        watch(1, 64, hi, rs);
        chk("2x high", 32, hi);
        chk("2x rises", 8, rs);
        watch(4, 64, hi, rs);
        chk("net0 high", 32, hi);
        watch(5, 64, hi, rs);
        chk("net1 high", 0, hi);
        watch(6, 64, hi, rs);
        chk("90 high", 32, hi);
        watch_eq(0, 6, 64, eq);
        chk("90 vs 1x agree", 32, eq);
        watch_eq(0, 7, 64, eq);
        chk("180 vs 1x agree", 0, eq);
        watch_eq(6, 8, 64, eq);
        chk("270 vs 90 agree", 0, eq);
        chk("done after lock", 1, cdone);
    endtask : t_lock
    task automatic t_div(input logic hf);
        int k, per;
        for (k = 0; k < 8; k++) begin
            if (hf && k != 1 && k != 2) continue;
            divide_ratio_setting = k[2:0];
            high_freq_mode = hf;
            per = r2[k] * 8;
            repeat (300) @(posedge ref_clk);
            #1;
            watch(2, 2 * per, hi, rs);
            chk("div rises", 2, rs);
            chk("div high", hf ? 2 * (r2[k] >> 1) * 8 : per, hi);
        end
        divide_ratio_setting = 3'h0;
        high_freq_mode = 1'b0;
    endtask : t_div
    task automatic t_rst();
        dll_reset_in = 1'b1;
        wait_lock(1'b0, 64);
        watch(1, 64, hi, rs);
        chk("2x unlocked high", 16, hi);
        chk("2x unlocked rises", 4, rs);
        dll_reset_in = 1'b0;
        wait_lock(1'b1, 2000);
    endtask : t_rst
    task automatic t_var();
        variant_select = dsk_pkg::VAR_HF;
        watch(1, 64, hi, rs);
        chk("hf 2x", 0, hi);
        watch(6, 64, hi, rs);
        chk("hf 90", 0, hi);
        watch(7, 64, hi, rs);
        chk("hf 180 high", 32, hi);
        variant_select = dsk_pkg::VAR_SIMPLE;
        watch(3, 64, hi, rs);
        chk("simple lock", 0, hi);
        watch(2, 64, hi, rs);
        chk("simple div", 0, hi);
        watch(0, 64, hi, rs);
        chk("simple 1x", 32, hi);
        // with correction off the 1x output is the source one ref cycle late
        duty_correct_enable = 1'b0;
        watch_eq(0, 9, 64, eq);
        chk("raw 1x vs source agree", 56, eq);
        duty_correct_enable = 1'b1;
        variant_select = dsk_pkg::VAR_FULL;
    endtask : t_var
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (6) @(posedge ref_clk);
        #2 srst = 1'b0;
        t_lock();
        t_div(1'b0);
        t_div(1'b1);
        t_rst();
        t_var();
        tally_and_finish();
    end
endmodule : deskew_clock_dll_tb_top

// file: verification/dsk_fabric_model.sv
// fabric-side model: a free-running source clock and a delayed return of the 1x output
// assumes ref_clk oversamples the source clock; the clock network delay is fixed
`timescale 1ns/1ps
module dsk_fabric_model #(
    parameter int PERIOD = 16,
    parameter int DELAY = 5
) (
    input wire logic ref_clk,
    input wire logic loop_clk,
    output logic source_clk,
    output logic feedback_clk
);
    int cnt = 0;
    logic [15:0] pipe = 16'h0000;
    // ----------------------------------------------------------------
    // source and return path
    // ----------------------------------------------------------------
    // steps just after the edge so the block never samples mid-change
    always @(posedge ref_clk) begin
        #1;
        cnt = (cnt + 1) % PERIOD;
        pipe = {pipe[14:0], loop_clk};
    end
    assign source_clk = (cnt < PERIOD / 2);
    // the 1x output returns on-chip, so the pad-feedback doubler rule never applies here
    assign feedback_clk = pipe[DELAY - 1];
endmodule : dsk_fabric_model
